// [pkg/pscd_pkg.sv]
package pscd_pkg;
    // Instruction opcodes (low 12 bits of the opcode word; anti-aliasing matched on bits 8:0 only)
    localparam logic [11:0] OPC_ACTIVITY   = 12'h030;
    localparam logic [11:0] OPC_AA_DIST    = 12'h037;
    localparam logic [11:0] OPC_BLOCK_SIZE = 12'h022;
    localparam logic [11:0] OPC_FONT_BASE  = 12'h063;
    localparam int OPC_LSB = 0;
    localparam int OPC_W   = 12;

    // Opcode word fields
    localparam int GRP_LSB      = 12;
    localparam int POS_LSB      = 9;
    localparam int FPS_LSB      = 14;
    localparam int CELL_BIT     = 13;
    localparam int RAXIS_BIT    = 12;

    // Parameter word fields
    localparam int BASE_X_LSB   = 8;
    localparam int BASE_Y_LSB   = 0;
    localparam int BASE_SHIFT   = 4;
    localparam int THR_MSB      = 3;

    // Execution times in system clock cycles
    localparam int CYC_ACTIVITY   = 112;
    localparam int CYC_AA_DIST    = 64;
    localparam int CYC_BLOCK_SIZE = 82;
    localparam int CYC_FONT_BASE  = 136;

    // Reset values
    localparam logic [3:0]  RST_ACTIVITY = 4'h0;
    localparam logic [15:0] RST_WORD     = 16'h0000;

    typedef enum {
        ST_IDLE,
        ST_PARAM,
        ST_WAIT_OPND,
        ST_BUSY
    } pscd_state_t;

    typedef enum {
        OP_ACTIVITY,
        OP_AA_DIST,
        OP_BLOCK_SIZE,
        OP_FONT_BASE
    } pscd_op_t;
endpackage

// [logic/pscd_timer.sv]
`timescale 1ns/1ps
// Counts out an instruction's execution time
module pscd_timer #(
    parameter int CW = 8
) (
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    input  wire logic          load_in,
    input  wire logic [CW-1:0] count_in,
    output logic               busy_out
);
    logic [CW-1:0] cnt_r;

    initial begin
        if (CW < 8) begin
            $error("pscd_timer: CW too small");
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_r <= '0;
        end else if (load_in) begin
            cnt_r <= count_in;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign busy_out = (cnt_r != '0);
endmodule

// [logic/pscd_write_gate.sv]
`timescale 1ns/1ps
// Per-plane write strobe gating by the activity mask
module pscd_write_gate #(
    parameter int PLANES = 4
) (
    input  wire logic [PLANES-1:0] active_in,
    input  wire logic              write_in,
    output logic      [PLANES-1:0] plane_we_out
);
    genvar p;
    generate
        for (p = 0; p < PLANES; p++) begin : g_plane
            assign plane_we_out[p] = write_in & active_in[p];
        end
    endgenerate
endmodule

// [logic/pscd_top.sv]
`timescale 1ns/1ps
// Operation
// - Active plane (bit 1) is written normally by drawing writes.
// - Inactive plane (bit 0) never gets its write strobe.
// - Nibble MSB maps to plane 0, LSB to plane 3.
// - Activity opcode: group in 15:12, then word of four device nibbles.
// - Anti-aliasing instruction ignored when position code mismatches.
// - Lower-threshold top bit 0 selects comparator, 1 inverse-distance.
// - Two threshold words: planes 1,0 then planes 3,2.
// - Anti-aliasing instruction takes 64 cycles, pen unchanged.
// - Block size stores evaluated pair as block and brush size.
// - Block size accepts any mode, pen position unchanged.
// - Block size instruction takes 82 cycles.
// - Two-bit font plane selector stored for string drawing.
// - One-bit cell-scale flag stored for string drawing.
// - Return axis 0 keeps X, 1 keeps Y of return pair.
// - Font base fields times 16 form 12-bit addresses.
// - Font base instruction takes 136 cycles, pen unchanged.
// - Font opcode fields 15:14,13,12; return pair then two base words.
// - Activity group mismatching position makes a no-operation.
// - Activity instruction takes 112 cycles, pen unchanged.
module pscd_top
    import pscd_pkg::*;
#(
    parameter int PLANES = 4,
    parameter int POS_W  = 6,
    parameter int CW     = 8
) (
    input  wire logic                 CORE_CLK_IN,
    input  wire logic                 RST_B_IN,
    input  wire logic [POS_W-1:0]     DEVICE_POSITION_CODE_IN,
    input  wire logic [15:0]          CMD_WORD_IN,
    input  wire logic                 CMD_VALID_IN,
    output logic                      CMD_READY_OUT,
    output logic                      OPND_REQ_OUT,
    output logic [15:0]               OPND_X_WORD_OUT,
    output logic [15:0]               OPND_Y_WORD_OUT,
    input  wire logic                 OPND_DONE_IN,
    input  wire logic [15:0]          OPND_X_IN,
    input  wire logic [15:0]          OPND_Y_IN,
    input  wire logic                 MEM_WRITE_IN,
    output logic [PLANES-1:0]         PLANE_WE_OUT,
    output logic [PLANES-1:0]         ACTIVITY_OUT,
    output logic [PLANES*4-1:0]       AA_MIN_OUT,
    output logic [PLANES*4-1:0]       AA_MAX_OUT,
    output logic                      AA_INV_DIST_OUT,
    output logic [15:0]               BLOCK_X_OUT,
    output logic [15:0]               BLOCK_Y_OUT,
    output logic [1:0]                FONT_PLANE_SELECT_OUT,
    output logic                      CELL_SCALE_OUT,
    output logic                      RETURN_AXIS_SELECT_OUT,
    output logic [15:0]               RETURN_COORD_OUT,
    output logic [11:0]               FONT0_BASE_X_OUT,
    output logic [11:0]               FONT0_BASE_Y_OUT,
    output logic [11:0]               FONT1_BASE_X_OUT,
    output logic [11:0]               FONT1_BASE_Y_OUT,
    output logic                      BUSY_OUT
);
    import pscd_pkg::*;

    initial begin
        if (PLANES != 4 || POS_W < 4 || POS_W > 7 || CW < 8) begin
            $error("pscd_top: unsupported parameters");
        end
    end

    // ----------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------
    pscd_state_t   state_r;
    pscd_state_t   state_nxt;
    pscd_op_t      op_r;
    logic [2:0]    pidx_r;
    logic [15:0]   w0_r;
    logic [15:0]   w1_r;
    logic [15:0]   w2_r;
    logic [15:0]   w3_r;
    logic [15:0]   opw_r;
    logic [POS_W-1:0] cmd_pos_r;
    logic          match_r;

    logic          take;
    logic          timer_busy;
    logic          timer_load;
    logic [CW-1:0] timer_count;
    logic [11:0]   opc;
    logic          is_act;
    logic          is_aa;
    logic          is_blk;
    logic          is_font;
    logic          is_known;
    logic [3:0]    cmd_grp;
    logic [POS_W-1:0] cmd_pos;
    logic [2:0]    nparams;
    logic          last_param;
    logic          op_needs_opnd;

    assign take     = CMD_VALID_IN & CMD_READY_OUT;
    assign opc      = CMD_WORD_IN[OPC_LSB +: OPC_W];
    assign is_act   = (opc == OPC_ACTIVITY);
    assign is_aa    = (CMD_WORD_IN[8:0] == OPC_AA_DIST[8:0]);
    assign is_blk   = (opc == OPC_BLOCK_SIZE);
    assign is_font  = (opc == OPC_FONT_BASE);
    assign is_known = is_act | is_aa | is_blk | is_font;
    assign cmd_grp  = CMD_WORD_IN[GRP_LSB +: 4];
    assign cmd_pos  = CMD_WORD_IN[15 -: POS_W];

    // Parameter words still to come after the opcode word
    assign nparams = (op_r == OP_ACTIVITY)   ? 3'd1 :
                     (op_r == OP_AA_DIST)    ? 3'd2 :
                     (op_r == OP_FONT_BASE)  ? 3'd4 : 3'd2;
    assign last_param    = (pidx_r == nparams - 3'd1);
    // Block size and return pair go through operand evaluation
    assign op_needs_opnd = (op_r == OP_BLOCK_SIZE)
                         | ((op_r == OP_FONT_BASE) && (pidx_r == 3'd1));

    assign CMD_READY_OUT = (state_r == ST_IDLE && !timer_busy) || (state_r == ST_PARAM);
    assign OPND_REQ_OUT  = (state_r == ST_WAIT_OPND);
    assign OPND_X_WORD_OUT = w0_r;
    assign OPND_Y_WORD_OUT = w1_r;
    assign BUSY_OUT      = (state_r != ST_IDLE) | timer_busy;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (take && is_known) begin
                    state_nxt = ST_PARAM;
                end
            end
            ST_PARAM: begin
                if (take && last_param) begin
                    state_nxt = ST_BUSY;
                end
                if (take && op_needs_opnd && pidx_r[0]) begin
                    state_nxt = ST_WAIT_OPND;
                end
            end
            ST_WAIT_OPND: begin
                if (OPND_DONE_IN) begin
                    state_nxt = (op_r == OP_FONT_BASE) ? ST_PARAM : ST_BUSY;
                end
            end
            ST_BUSY: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            op_r      <= OP_ACTIVITY;
            pidx_r    <= '0;
            match_r   <= 1'b0;
            cmd_pos_r <= '0;
        end else if (state_r == ST_IDLE && take) begin
            op_r      <= is_act ? OP_ACTIVITY : is_aa ? OP_AA_DIST :
                         is_blk ? OP_BLOCK_SIZE : OP_FONT_BASE;
            pidx_r    <= '0;
            cmd_pos_r <= cmd_pos;
            match_r   <= is_act ? (cmd_grp == DEVICE_POSITION_CODE_IN[POS_W-1:2])
                                : (cmd_pos == DEVICE_POSITION_CODE_IN);
        end else if (state_r == ST_PARAM && take) begin
            pidx_r <= pidx_r + 3'd1;
        end
    end

    // Parameter word capture
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            w0_r <= RST_WORD;
            w1_r <= RST_WORD;
            w2_r <= RST_WORD;
            w3_r <= RST_WORD;
            opw_r <= RST_WORD;
        end else if (state_r == ST_IDLE && take) begin
            // Opcode word kept apart so the font words cannot overwrite its flags
            opw_r <= CMD_WORD_IN;
        end else if (state_r == ST_PARAM && take) begin
            unique case (pidx_r)
                3'd0:    w0_r <= CMD_WORD_IN;
                3'd1:    w1_r <= CMD_WORD_IN;
                3'd2:    w2_r <= CMD_WORD_IN;
                default: w3_r <= CMD_WORD_IN;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Execution timing
    // ----------------------------------------------------------------
    // fixed instruction times
    assign timer_load  = (state_r == ST_BUSY);
    assign timer_count = (op_r == OP_ACTIVITY)   ? CW'(CYC_ACTIVITY - 2)   :
                         (op_r == OP_AA_DIST)    ? CW'(CYC_AA_DIST - 2)    :
                         (op_r == OP_BLOCK_SIZE) ? CW'(CYC_BLOCK_SIZE - 2) :
                                                   CW'(CYC_FONT_BASE - 2);

    pscd_timer #(
        .CW (CW)
    ) u_timer (
        .clk_in   (CORE_CLK_IN),
        .rst_b_in (RST_B_IN),
        .load_in  (timer_load),
        .count_in (timer_count),
        .busy_out (timer_busy)
    );

    // ----------------------------------------------------------------
    // Setting registers
    // ----------------------------------------------------------------
    logic [PLANES-1:0]   act_r;
    logic [PLANES-1:0]   act_nib;
    logic [3:0]          nib_sel;
    logic [PLANES*4-1:0] min_r;
    logic [PLANES*4-1:0] max_r;
    logic                inv_r;
    logic [15:0]         blk_x_r;
    logic [15:0]         blk_y_r;
    logic [1:0]          fps_r;
    logic                cell_r;
    logic                raxis_r;
    logic [15:0]         ret_r;
    logic [7:0]          f0x_r;
    logic [7:0]          f0y_r;
    logic [7:0]          f1x_r;
    logic [7:0]          f1y_r;
    logic                commit;
    logic                opnd_commit;

    assign commit      = (state_r == ST_BUSY);
    assign opnd_commit = (state_r == ST_WAIT_OPND) && OPND_DONE_IN;

    // nibble of this device within its group
    assign nib_sel = w0_r[DEVICE_POSITION_CODE_IN[1:0]*4 +: 4];
    genvar p;
    generate
        for (p = 0; p < PLANES; p++) begin : g_nib
            assign act_nib[p] = nib_sel[3 - p];
        end
    endgenerate

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            act_r <= RST_ACTIVITY;
        end else if (commit && op_r == OP_ACTIVITY && match_r) begin
            act_r <= act_nib;
        end
    end

    // word 1: planes 1,0; word 2: planes 3,2
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            min_r <= '0;
            max_r <= '0;
            inv_r <= 1'b0;
        end else if (commit && op_r == OP_AA_DIST && match_r) begin
            min_r <= {w1_r[15:12], w1_r[7:4], w0_r[15:12], w0_r[7:4]};
            max_r <= {w1_r[11:8], w1_r[3:0], w0_r[11:8], w0_r[3:0]};
            inv_r <= w0_r[4 + THR_MSB];
        end
    end

    // evaluated pair becomes block and brush size
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            blk_x_r <= RST_WORD;
            blk_y_r <= RST_WORD;
        end else if (opnd_commit && op_r == OP_BLOCK_SIZE) begin
            blk_x_r <= OPND_X_IN;
            blk_y_r <= OPND_Y_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            fps_r   <= 2'b00;
            cell_r  <= 1'b0;
            raxis_r <= 1'b0;
            ret_r   <= RST_WORD;
            f0x_r   <= '0;
            f0y_r   <= '0;
            f1x_r   <= '0;
            f1y_r   <= '0;
        end else if (op_r == OP_FONT_BASE) begin
            if (opnd_commit) begin
                // keep X when 0, Y when 1
                ret_r <= opw_r[RAXIS_BIT] ? OPND_Y_IN : OPND_X_IN;
            end
            if (commit) begin
                fps_r   <= opw_r[FPS_LSB +: 2];
                cell_r  <= opw_r[CELL_BIT];
                raxis_r <= opw_r[RAXIS_BIT];
                f0x_r   <= w2_r[BASE_X_LSB +: 8];
                f0y_r   <= w2_r[BASE_Y_LSB +: 8];
                f1x_r   <= w3_r[BASE_X_LSB +: 8];
                f1y_r   <= w3_r[BASE_Y_LSB +: 8];
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // write strobes gated per plane
    pscd_write_gate #(
        .PLANES (PLANES)
    ) u_gate (
        .active_in    (act_r),
        .write_in     (MEM_WRITE_IN),
        .plane_we_out (PLANE_WE_OUT)
    );

    assign ACTIVITY_OUT           = act_r;
    assign AA_MIN_OUT             = min_r;
    assign AA_MAX_OUT             = max_r;
    assign AA_INV_DIST_OUT        = inv_r;
    assign BLOCK_X_OUT            = blk_x_r;
    assign BLOCK_Y_OUT            = blk_y_r;
    assign FONT_PLANE_SELECT_OUT  = fps_r;
    assign CELL_SCALE_OUT         = cell_r;
    assign RETURN_AXIS_SELECT_OUT = raxis_r;
    assign RETURN_COORD_OUT       = ret_r;
    assign FONT0_BASE_X_OUT       = {f0x_r, 4'h0};
    assign FONT0_BASE_Y_OUT       = {f0y_r, 4'h0};
    assign FONT1_BASE_X_OUT       = {f1x_r, 4'h0};
    assign FONT1_BASE_Y_OUT       = {f1y_r, 4'h0};
endmodule

// [tb/pscd_top_asserts.sv]
`timescale 1ns/1ps
module pscd_top_asserts
    import pscd_pkg::*;
#(
    parameter int PLANES = 4,
    parameter int POS_W  = 6,
    parameter int CW     = 8
) (
    input wire logic                CORE_CLK_IN,
    input wire logic                RST_B_IN,
    input wire logic                CMD_READY_OUT,
    input wire logic                OPND_REQ_OUT,
    input wire logic                OPND_DONE_IN,
    input wire logic [15:0]         OPND_X_IN,
    input wire logic [15:0]         OPND_X_WORD_OUT,
    input wire logic                MEM_WRITE_IN,
    input wire logic [PLANES-1:0]   PLANE_WE_OUT,
    input wire logic [PLANES-1:0]   ACTIVITY_OUT,
    input wire logic [PLANES*4-1:0] AA_MIN_OUT,
    input wire logic                AA_INV_DIST_OUT,
    input wire logic [15:0]         BLOCK_X_OUT,
    input wire logic [11:0]         FONT0_BASE_X_OUT,
    input wire logic [11:0]         FONT1_BASE_Y_OUT,
    input wire logic                BUSY_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    localparam int LIM = 140;
    logic [7:0] low_cnt_r;

    // Cycles with the command port closed and no operand pending
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            low_cnt_r <= 8'h00;
        end else if (CMD_READY_OUT || OPND_REQ_OUT) begin
            low_cnt_r <= 8'h00;
        end else begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end

    we_gate_a: assert property (PLANE_WE_OUT == (ACTIVITY_OUT & {PLANES{MEM_WRITE_IN}}))
        else $error("plane strobe differs from write and activity");
    inactive_quiet_a: assert property ((PLANE_WE_OUT & ~ACTIVITY_OUT) == '0)
        else $error("inactive plane strobed");
    aa_method_a: assert property (AA_INV_DIST_OUT == AA_MIN_OUT[THR_MSB])
        else $error("method flag differs from lower threshold top bit");
    base_nibble_a: assert property (
        FONT0_BASE_X_OUT[3:0] == 4'h0 && FONT1_BASE_Y_OUT[3:0] == 4'h0)
        else $error("font base low bits not zero");
    opnd_hold_a: assert property (
        OPND_REQ_OUT && !OPND_DONE_IN |=> OPND_REQ_OUT && $stable(OPND_X_WORD_OUT))
        else $error("operand request dropped or changed");
    block_src_a: assert property (
        !$stable(BLOCK_X_OUT) |->
        BLOCK_X_OUT == $past(OPND_X_IN) || BLOCK_X_OUT == $past(OPND_X_IN, 2))
        else $error("block size not from evaluated operand");
    commit_busy_a: assert property (
        !$stable(ACTIVITY_OUT) || !$stable(AA_MIN_OUT) |-> BUSY_OUT)
        else $error("setting changed outside execution");
    exec_bound_a: assert property (low_cnt_r <= LIM)
        else $error("command port closed too long");

    cover property ($rose(OPND_REQ_OUT));
    cover property ($fell(CMD_READY_OUT));
    cover property (|PLANE_WE_OUT);
endmodule

bind pscd_top pscd_top_asserts #(.PLANES(PLANES), .POS_W(POS_W), .CW(CW)) u_chk (
    .CORE_CLK_IN, .RST_B_IN, .CMD_READY_OUT, .OPND_REQ_OUT, .OPND_DONE_IN,
    .OPND_X_IN, .OPND_X_WORD_OUT, .MEM_WRITE_IN, .PLANE_WE_OUT, .ACTIVITY_OUT,
    .AA_MIN_OUT, .AA_INV_DIST_OUT, .BLOCK_X_OUT, .FONT0_BASE_X_OUT,
    .FONT1_BASE_Y_OUT, .BUSY_OUT
);

// [tb/pscd_host_model.sv]
`timescale 1ns/1ps
module pscd_host_model (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [1:0]  slow_in,
    input  wire logic        cmd_ready_in,
    input  wire logic        opnd_req_in,
    input  wire logic [15:0] opnd_x_word_in,
    input  wire logic [15:0] opnd_y_word_in,
    output logic      [15:0] cmd_word_out,
    output logic             cmd_valid_out,
    output logic             opnd_done_out,
    output logic      [15:0] opnd_x_out,
    output logic      [15:0] opnd_y_out
);
    logic [15:0] fifo_q[$];

    task automatic push(input logic [15:0] w);
        fifo_q.push_back(w);
    endtask

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fifo_q.delete();
            cmd_valid_out <= 1'b0;
            opnd_done_out <= 1'b0;
            cmd_word_out  <= 16'h0000;
            opnd_x_out    <= 16'h0000;
            opnd_y_out    <= 16'h0000;
        end else begin
            if (cmd_valid_out && cmd_ready_in) begin
                void'(fifo_q.pop_front());
            end
            // Word held until taken; idle bus shows changing data
            if (!cmd_valid_out || cmd_ready_in) begin
                if (fifo_q.size() > 0 && slow_in[0]) begin
                    cmd_valid_out <= 1'b1;
                    cmd_word_out  <= fifo_q[0];
                end else begin
                    cmd_valid_out <= 1'b0;
                    cmd_word_out  <= ~cmd_word_out;
                end
            end
            if (opnd_req_in && !opnd_done_out && slow_in[1]) begin
                opnd_done_out <= 1'b1;
                opnd_x_out    <= {2'b00, opnd_x_word_in[13:0]};
                opnd_y_out    <= {2'b00, opnd_y_word_in[13:0]};
            end else begin
                opnd_done_out <= 1'b0;
                opnd_x_out    <= ~opnd_x_out;
                opnd_y_out    <= ~opnd_y_out;
            end
        end
    end
endmodule

// [tb/pscd_top_test.sv]
`timescale 1ns/1ps
module pscd_top_test;
    import pscd_pkg::*;
    logic        clk, rst_b, mem_wr, cmd_valid, cmd_ready, opnd_req, opnd_done;
    logic        aa_inv, cell_sc, ret_ax, busy;
    logic [1:0]  slow, font_sel;
    logic [3:0]  act, plane_we, grp, e_act, e_cfg;
    logic [5:0]  pos, pw;
    logic [11:0] f0x, f0y, f1x, f1y, e_b[4];
    logic [15:0] cmd_word, ox_word, oy_word, ox, oy, aa_min, aa_max, bx, by, ret;
    logic [15:0] e_min, e_max, e_bx, e_by, e_ret;
    logic [31:0] seed, r, w, rd;
    int          errors, checks, n;
    int          cyc = 0;
    int          last_cyc = 0;

    pscd_top #(.PLANES(4), .POS_W(6), .CW(8)) dut (
        .CORE_CLK_IN(clk), .RST_B_IN(rst_b), .DEVICE_POSITION_CODE_IN(pos),
        .CMD_WORD_IN(cmd_word), .CMD_VALID_IN(cmd_valid), .CMD_READY_OUT(cmd_ready),
        .OPND_REQ_OUT(opnd_req), .OPND_X_WORD_OUT(ox_word), .OPND_Y_WORD_OUT(oy_word),
        .OPND_DONE_IN(opnd_done), .OPND_X_IN(ox), .OPND_Y_IN(oy), .MEM_WRITE_IN(mem_wr),
        .PLANE_WE_OUT(plane_we), .ACTIVITY_OUT(act), .AA_MIN_OUT(aa_min),
        .AA_MAX_OUT(aa_max), .AA_INV_DIST_OUT(aa_inv), .BLOCK_X_OUT(bx), .BLOCK_Y_OUT(by),
        .FONT_PLANE_SELECT_OUT(font_sel), .CELL_SCALE_OUT(cell_sc),
        .RETURN_AXIS_SELECT_OUT(ret_ax), .RETURN_COORD_OUT(ret),
        .FONT0_BASE_X_OUT(f0x), .FONT0_BASE_Y_OUT(f0y), .FONT1_BASE_X_OUT(f1x),
        .FONT1_BASE_Y_OUT(f1y), .BUSY_OUT(busy)
    );
    pscd_host_model host (
        .clk_in(clk), .rst_b_in(rst_b), .slow_in(slow), .cmd_ready_in(cmd_ready),
        .opnd_req_in(opnd_req), .opnd_x_word_in(ox_word), .opnd_y_word_in(oy_word),
        .cmd_word_out(cmd_word), .cmd_valid_out(cmd_valid), .opnd_done_out(opnd_done),
        .opnd_x_out(ox), .opnd_y_out(oy)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [3:0] act_map(input logic [15:0] bits, input logic [1:0] dev);
        logic [3:0] nib;
        nib = bits[dev*4 +: 4];
        return {nib[0], nib[1], nib[2], nib[3]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_time(input int got, input int exp);
        checks++;
        if (got != exp) begin
            errors++;
            $display("ERROR %0t took %0d cycles, expected %0d", $time, got, exp);
        end
    endtask
    task automatic clear_exp();
        e_act = '0; e_min = '0; e_max = '0; e_bx = '0; e_by = '0;
        e_ret = '0; e_cfg = '0; e_b = '{default: '0};
    endtask
    task automatic check_all();
        chk({14'h0000, cmd_ready, busy}, 16'h0002);
        chk({12'h000, act}, {12'h000, e_act});
        chk({12'h000, plane_we}, {12'h000, e_act & {4{mem_wr}}});
        chk(aa_min, e_min);
        chk(aa_max, e_max);
        chk({15'h0000, aa_inv}, {15'h0000, e_min[3]});
        chk(bx, e_bx);
        chk(by, e_by);
        chk({12'h000, font_sel, cell_sc, ret_ax}, {12'h000, e_cfg});
        chk(ret, e_ret);
        chk({f0x, f0y[11:8]}, {e_b[0], e_b[1][11:8]});
        chk({f1x, f1y[11:8]}, {e_b[2], e_b[3][11:8]});
        chk({f0y[7:0], f1y[7:0]}, {e_b[1][7:0], e_b[3][7:0]});
    endtask
    task automatic run(input int exp);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(cmd_ready === 1'b1 && busy === 1'b0 && cmd_valid === 1'b0 &&
                     host.fifo_q.size() == 0 && cyc - last_cyc > 8) && n < 600);
        if (n >= 600) begin
            errors++;
            $display("ERROR %0t instruction never finished", $time);
            end_sim();
        end
        chk_time(cyc - last_cyc, exp);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, random inputs and timing monitor
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        rd = xs();
        mem_wr <= rd[0];
        slow <= rd[2:1];
        cyc <= cyc + 1;
        if ((cmd_valid && cmd_ready) || opnd_done) begin
            last_cyc <= cyc;
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        seed = 32'h0000_e066;
        errors = 0; checks = 0;
        rst_b = 1'b0; pos = 6'h00;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        clear_exp();
        @(posedge clk);
        check_all();
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            r = xs();
            pos <= r[5:0];
            grp = (i % 3 == 0) ? r[9:6] : r[5:2];
            // Last pass: a three-plane device, host clears the plane 3 bits
            w = (i == 11) ? (r & 32'hEEEE_FFFF) : r;
            host.push({grp, OPC_ACTIVITY});
            host.push(w[31:16]);
            if (grp == r[5:2]) e_act = act_map(w[31:16], r[1:0]);
            run(CYC_ACTIVITY);
            check_all();
        end
        $display("activity test done");
        for (int i = 0; i < 12; i++) begin
            r = xs();
            w = xs();
            pos <= r[5:0];
            pw = (i % 3 == 0) ? r[11:6] : r[5:0];
            w[31] = w[23]; w[15] = w[23]; w[7] = w[23];
            host.push({pw, 1'b0, OPC_AA_DIST[8:0]});
            host.push(w[31:16]);
            host.push(w[15:0]);
            if (pw == r[5:0]) begin
                e_min = {w[15:12], w[7:4], w[31:28], w[23:20]};
                e_max = {w[11:8], w[3:0], w[27:24], w[19:16]};
            end
            run(CYC_AA_DIST);
            check_all();
        end
        $display("threshold test done");
        for (int i = 0; i < 6; i++) begin
            w = xs();
            host.push({4'h0, OPC_BLOCK_SIZE});
            host.push(w[31:16]);
            host.push({2'b00, w[13:0]});
            e_bx = {2'b00, w[29:16]};
            e_by = {2'b00, w[13:0]};
            run(CYC_BLOCK_SIZE);
            check_all();
        end
        $display("block size test done");
        for (int i = 0; i < 8; i++) begin
            r = xs();
            w = xs();
            host.push({r[3:0], OPC_FONT_BASE});
            host.push(r[31:16]);
            host.push({2'b00, r[13:0]});
            host.push(w[31:16]);
            host.push(w[15:0]);
            e_cfg = r[3:0];
            e_ret = r[0] ? {2'b00, r[13:0]} : {2'b00, r[29:16]};
            e_b = '{{w[31:24], 4'h0}, {w[23:16], 4'h0}, {w[15:8], 4'h0}, {w[7:0], 4'h0}};
            run(CYC_FONT_BASE);
            check_all();
        end
        $display("font base test done");
        host.push({4'hF, OPC_FONT_BASE});
        repeat (3) @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        clear_exp();
        @(posedge clk);
        check_all();
        $display("mid-run reset test done");
        end_sim();
    end
endmodule
